// *** hw/slt_pkg.sv ***
package slt_pkg;

   // Clock rate and the printed times, each in its own unit
   localparam int CLK_MHZ = 200;
   localparam int SLOT_MS = 250; // One eighth of the 2 s fault pattern
   localparam int FAULT_PERIOD_MS = 2000;
   localparam int BOOT_DELAY_MS = 15000;
   localparam int INIT_MAX_MS = 120000;
   localparam int COMM_MS = 500;
   localparam int PULSE_NS = 1000;

   // Derived cycle counts
   localparam int SLOT_CYC = SLOT_MS * 1000 * CLK_MHZ;
   localparam int COMM_CYC = COMM_MS * 1000 * CLK_MHZ;
   localparam int SLOTS_PER_PERIOD = FAULT_PERIOD_MS / SLOT_MS;
   localparam int BOOT_SLOTS = BOOT_DELAY_MS / SLOT_MS;
   localparam int INIT_SLOTS = INIT_MAX_MS / SLOT_MS;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W = 27;

   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_WIDTH = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;

   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_BEAM_BIT = 2;
   localparam int CTRL_POL_BIT = 3;
   localparam int CTRL_AUX_BIT = 4;

   typedef enum logic [1:0] {
      TM_EOV = 2'h0,
      TM_DET = 2'h1,
      TM_PRES = 2'h2
   } slt_tmode_type;

   typedef enum logic [2:0] {
      ST_PWR = 3'h0,
      ST_BOOT = 3'h1,
      ST_BAD = 3'h2,
      ST_INIT = 3'h3,
      ST_CAL = 3'h4,
      ST_NORM = 3'h5
   } slt_state_type;

   typedef struct packed {
      logic [1:0] mode;
      logic beam2;
      logic act_high;
      logic aux_fit;
      logic [15:0] width;
   } slt_cfg_type;

   typedef struct packed {
      logic det1;
      logic det2;
      logic eov1;
      logic eov2;
   } slt_evt_type;

   typedef struct packed {
      logic image_ok;
      logic image_bad;
      logic selftest_fail;
      logic init_done;
      logic cal_done;
      logic noncrit_fail;
      logic crit_fail;
   } slt_sys_type;

   // Reset values
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic BEAM2_RST = 1'b1;
   localparam logic POL_RST = 1'b0;
   localparam logic AUX_RST = 1'b0;
   localparam logic [15:0] WIDTH_RST = 16'(PULSE_CYC);

endpackage

// *** hw/slt_trig_gen.sv ***
`timescale 1ns/1ps
module slt_trig_gen (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Synchronised reset, active low
   input wire slt_pkg::slt_cfg_type cfg, // Trigger configuration
   input wire slt_pkg::slt_evt_type evt, // Beam event pulses
   input wire logic present, // Vehicle in second beam
   input wire logic comm_inv, // Comm check window
   output logic trig_q, // Main trigger pin level
   output logic aux_q // Auxiliary trigger pin level
);
   import slt_pkg::*;

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] width_w;
   logic det_sel, eov_sel, fire, active, lvl_d, ah_w;

   assign width_w = cfg.width;
   assign ah_w = cfg.act_high;
   // Beam choice only steers the trigger, never detection itself
   assign det_sel = cfg.beam2 ? evt.det2 : evt.det1;
   assign eov_sel = cfg.beam2 ? evt.eov2 : evt.eov1;
   assign fire = (cfg.mode == TM_EOV && eov_sel) ||
                 (cfg.mode == TM_DET && det_sel);
   // programmable width, a new event restarts the pulse
   assign cnt_d = fire ? width_w :
                  (cnt_q != 16'h0) ? cnt_q - 16'h1 : cnt_q;
   assign active = (cnt_q != 16'h0) ||
                   (cfg.mode == TM_PRES && present);
   assign lvl_d = (active ? ah_w : !ah_w) ^ comm_inv;

   // Pulse counter and pin registers; unfitted aux rests inactive
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0;
         trig_q <= 1'b1;
         aux_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         trig_q <= lvl_d;
         aux_q <= cfg.aux_fit ? lvl_d : !ah_w;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_pulse_load: assert property (fire |=> cnt_q == $past(width_w))
      else $error("pulse counter not loaded");
   chk_pulse_count: assert property (
      cnt_q > 16'h1 && !fire |=> cnt_q == $past(cnt_q) - 16'h1)
      else $error("pulse counter did not step");
   chk_pulse_level: assert property (
      cnt_q != 16'h0 && !comm_inv |=> trig_q == $past(ah_w))
      else $error("pulse not at active level");
   chk_presence_level: assert property (
      cfg.mode == TM_PRES && cnt_q == 16'h0 && !comm_inv
      |=> trig_q == ($past(present) ? $past(ah_w) : !$past(ah_w)))
      else $error("presence level wrong");
   chk_aux_copy: assert property (cfg.aux_fit |=> aux_q == trig_q)
      else $error("aux differs from main");
   cov_pulse_done: cover property (cnt_q == 16'h1 ##1 cnt_q == 16'h0);

endmodule

// *** hw/slt_led_trig.sv ***
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - At power-up both red and green indicators are off.
// - Valid image and parameters in boot: green flashes continuously.
// - After boot delay, red and green alternate during init, bounded time.
// - Road calibration: green on, red off; red on when done.
// - Normal operation keeps red continuously on.
// - Normal with no vehicle in second beam: both indicators on.
// - Detection in second beam turns green off.
// - End-of-vehicle in second beam turns green back on.
// - Comm check inverts green for half a second, then restores.
// - Comm check switches the trigger output with the same timing.
// - Invalid image or parameters in boot: red flashes steadily.
// - Non-critical failure: one red flash per two seconds, green kept.
// - Critical failure: four red flashes every two seconds.
// - Boot self-test failure: green off, red flashing, no initialisation.
// - Trigger output defaults to active low logic level.
// - Fitted auxiliary trigger behaves exactly like the main one.
// - Stored setting picks end-of-vehicle pulse, detection pulse, presence.
// - Trigger mode affects only trigger generation, not detection.
// - Pulse fires on detection or end-of-vehicle, first or second beam.
// - Pulse defaults to one microsecond active low; width, polarity set.
// - Presence mode holds trigger active while a vehicle is in beam two.
// - Detection pulse fires on selected beam detection before its message.
module slt_led_trig #(
   parameter int SLOT_CYCLES = slt_pkg::SLOT_CYC, // Flash slot length
   parameter int COMM_CYCLES = slt_pkg::COMM_CYC // Comm check window
) (
   input wire logic sys_clk, // System clock, 200 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [3:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_we, // Write strobe
   input wire logic reg_re, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   input wire slt_pkg::slt_sys_type sys_flags, // System state levels
   input wire slt_pkg::slt_evt_type veh_evt, // Beam event pulses
   input wire logic comm_check, // Comm check command pulse
   output logic red_led, // Red indicator, high is lit
   output logic green_led, // Green indicator, high is lit
   output logic vehicle_trigger_out, // Main trigger pin
   output logic aux_trigger_out // Auxiliary trigger pin
);
   import slt_pkg::*;

   logic rst_s1_q, rst_n_q;
   slt_state_type state_q, state_d;
   slt_cfg_type cfg_q;
   logic [TMR_W-1:0] slot_cnt_q, comm_tmr_q;
   logic [2:0] slot_q;
   logic [8:0] ph_q;
   logic [3:0] veh_cnt_q;
   logic red_d, green_d;
   logic slot_tick, blink, slot0, comm_act, present, app_run;
   logic is_bad, boot_done, init_to, wr_ctrl, wr_width;
   logic veh_up, veh_dn;
   logic [31:0] rd_mux;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // slot timer sets all flash rates
   assign slot_tick = slot_cnt_q == TMR_W'(SLOT_CYCLES - 1);
   assign blink = slot_q[0];
   assign slot0 = slot_q == 3'h0;

   // Slot counter and slot index; eight slots make one 2 s period
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         slot_cnt_q <= '0;
         slot_q <= 3'h0;
      end else begin
         slot_cnt_q <= slot_tick ? '0 : slot_cnt_q + 1'b1;
         slot_q <= slot_tick ? slot_q + 3'h1 : slot_q;
      end
   end

   // Slots spent in the current state, for boot delay and init bound
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ph_q <= 9'h0;
      end else if (state_d != state_q) begin
         ph_q <= 9'h0;
      end else if (slot_tick) begin
         ph_q <= ph_q + 9'h1;
      end
   end

   // Sequencing decodes
   assign is_bad = sys_flags.image_bad || sys_flags.selftest_fail;
   assign boot_done = slot_tick && ph_q == 9'(BOOT_SLOTS - 1);
   assign init_to = slot_tick && ph_q == 9'(INIT_SLOTS - 1);
   assign app_run = state_q == ST_INIT || state_q == ST_CAL ||
                    state_q == ST_NORM;

   // Indicator sequencer; a failed boot never leaves its state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_PWR: begin
            if (is_bad) begin
               state_d = ST_BAD;
            end else if (sys_flags.image_ok) begin
               state_d = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (is_bad) begin
               state_d = ST_BAD;
            end else if (boot_done) begin
               state_d = ST_INIT;
            end
         end
         ST_BAD: state_d = ST_BAD;
         // init ends on done or timeout
         ST_INIT: begin
            if (sys_flags.init_done || init_to) begin
               state_d = ST_CAL;
            end
         end
         ST_CAL: begin
            if (sys_flags.cal_done) begin
               state_d = ST_NORM;
            end
         end
         ST_NORM: state_d = ST_NORM;
         default: state_d = ST_PWR;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_PWR;
      end else begin
         state_q <= state_d;
      end
   end

   // Vehicles inside the second beam; counting keeps several presences
   assign veh_up = veh_evt.det2 && veh_cnt_q != 4'hf;
   assign veh_dn = veh_evt.eov2 && veh_cnt_q != 4'h0;
   assign present = veh_cnt_q != 4'h0;

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         veh_cnt_q <= 4'h0;
      end else if (veh_up && !veh_dn) begin
         veh_cnt_q <= veh_cnt_q + 4'h1;
      end else if (veh_dn && !veh_up) begin
         veh_cnt_q <= veh_cnt_q - 4'h1;
      end
   end

   // half second window; a new check restarts it
   assign comm_act = comm_tmr_q != '0;
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         comm_tmr_q <= '0;
      end else if (comm_check) begin
         comm_tmr_q <= TMR_W'(COMM_CYCLES);
      end else if (comm_act) begin
         comm_tmr_q <= comm_tmr_q - 1'b1;
      end
   end

   // Indicator pattern per state, then fault overlay, then comm check
   always_comb begin
      red_d = 1'b0;
      green_d = 1'b0;
      unique case (state_q)
         ST_PWR: ;
         ST_BOOT: green_d = blink;
         ST_BAD: red_d = blink;
         ST_INIT: begin
            red_d = blink;
            green_d = !blink;
         end
         ST_CAL: green_d = 1'b1;
         // red on, green shows free beam
         ST_NORM: begin
            red_d = 1'b1;
            green_d = !present;
         end
         default: ;
      endcase
      // critical: four flashes, one per even slot; non-critical: one flash in slot 0
      if (app_run && sys_flags.crit_fail) begin
         red_d = !blink;
      end else if (app_run && sys_flags.noncrit_fail) begin
         red_d = slot0;
      end
      green_d = green_d ^ comm_act;
   end

   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         red_led <= 1'b0;
         green_led <= 1'b0;
      end else begin
         red_led <= red_d;
         green_led <= green_d;
      end
   end

   // Register decode
   assign wr_ctrl = reg_we && reg_addr == ADDR_CTRL;
   assign wr_width = reg_we && reg_addr == ADDR_WIDTH;
   assign rd_mux =
      (reg_addr == ADDR_CTRL) ? {27'h0, cfg_q.aux_fit, cfg_q.act_high,
                                 cfg_q.beam2, cfg_q.mode} :
      (reg_addr == ADDR_WIDTH) ? {16'h0, cfg_q.width} :
      (reg_addr == ADDR_STATUS) ? {22'h0, veh_cnt_q, vehicle_trigger_out,
                                   green_led, red_led, state_q} :
      32'h0;

   // stored trigger setting; writes to status are ignored
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_q <= {MODE_RST, BEAM2_RST, POL_RST, AUX_RST, WIDTH_RST};
      end else begin
         if (wr_ctrl) begin
            cfg_q.mode <= reg_wdata[CTRL_MODE_LSB +: 2];
            cfg_q.beam2 <= reg_wdata[CTRL_BEAM_BIT];
            cfg_q.act_high <= reg_wdata[CTRL_POL_BIT];
            cfg_q.aux_fit <= reg_wdata[CTRL_AUX_BIT];
         end
         if (wr_width) begin
            cfg_q.width <= reg_wdata[15:0];
         end
      end
   end

   // Read data stand for one cycle only, zero otherwise
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_re ? rd_mux : 32'h0;
      end
   end

   // trigger sees events only, never alters them
   slt_trig_gen u_trig (
      .sys_clk(sys_clk),
      .rst_n(rst_n_q),
      .cfg(cfg_q),
      .evt(veh_evt),
      .present(present),
      .comm_inv(comm_act),
      .trig_q(vehicle_trigger_out),
      .aux_q(aux_trigger_out)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n_q);

   chk_pwr_dark: assert property (
      state_q == ST_PWR && !comm_act |=> !red_led && !green_led)
      else $error("indicators lit at power-up");
   chk_boot_flash: assert property (
      state_q == ST_BOOT && !comm_act |=> green_led == $past(blink))
      else $error("green not flashing in boot");
   chk_init_alt: assert property (
      state_q == ST_INIT && !comm_act && !sys_flags.crit_fail &&
      !sys_flags.noncrit_fail |=> red_led != green_led)
      else $error("init not alternating");
   chk_init_bound: assert property (
      state_q == ST_INIT && init_to |=> state_q == ST_CAL)
      else $error("init outlived its bound");
   chk_cal_leds: assert property (
      state_q == ST_CAL && !comm_act && !sys_flags.crit_fail &&
      !sys_flags.noncrit_fail |=> green_led && !red_led)
      else $error("calibration pattern wrong");
   chk_normal_red: assert property (
      state_q == ST_NORM && !sys_flags.crit_fail &&
      !sys_flags.noncrit_fail |=> red_led)
      else $error("red not on in normal");
   chk_idle_green: assert property (
      state_q == ST_NORM && !present && !comm_act |=> green_led)
      else $error("green off with beam free");
   chk_green_det: assert property (
      state_q == ST_NORM && veh_evt.det2 && !veh_evt.eov2 && !comm_act &&
      !comm_check ##1 !comm_check |=> !green_led)
      else $error("green not off on detection");
   chk_green_eov: assert property (
      state_q == ST_NORM && veh_evt.eov2 && !veh_evt.det2 &&
      veh_cnt_q == 4'h1 && !comm_act && !comm_check ##1 !comm_check
      |=> green_led)
      else $error("green not back on at exit");
   chk_comm_load: assert property (
      comm_check |=> comm_tmr_q == TMR_W'(COMM_CYCLES))
      else $error("comm window not started");
   chk_comm_trig: assert property (
      comm_act && !$past(comm_act) |=> vehicle_trigger_out !=
      $past(vehicle_trigger_out) || veh_evt != '0 || $past(veh_evt) != '0)
      else $error("trigger not switched by comm check");
   chk_bad_stay: assert property (
      state_q == ST_BAD |=> state_q == ST_BAD &&
      !green_led == !$past(comm_act))
      else $error("failed boot left or lit green");
   chk_noncrit_flash: assert property (
      app_run && sys_flags.noncrit_fail && !sys_flags.crit_fail
      |=> red_led == $past(slot0))
      else $error("non-critical flash wrong");
   chk_crit_flash: assert property (
      app_run && sys_flags.crit_fail |=> red_led == !$past(blink))
      else $error("critical flash wrong");

   cov_normal: cover property (state_q == ST_CAL ##1 state_q == ST_NORM);
   cov_comm: cover property (comm_check ##1 comm_act);
   cov_bad: cover property (state_q == ST_PWR ##1 state_q == ST_BAD);

endmodule

// *** verification/slt_cam_model.sv ***
`timescale 1ns/1ps
// Camera trigger input: counts active periods and their width in cycles
module slt_cam_model (
   input wire logic sys_clk, // Sampling clock
   input wire logic trig_pin, // Trigger line from the sensor
   input wire logic act_high, // Level that means active
   output int pulses, // Completed active periods
   output int last_w // Width of the last period
);
   int run = 0;

   // Counters start clean; the camera has no reset pin of its own
   initial begin
      pulses = 0;
      last_w = 0;
   end

   // A period is counted on its inactive edge, so a stuck line never counts
   always @(posedge sys_clk) begin
      if (trig_pin === act_high) begin
         run <= run + 1;
      end else if (run != 0) begin
         pulses <= pulses + 1;
         last_w <= run;
         run <= 0;
      end
   end
endmodule

// *** verification/slt_led_trig_test.sv ***
`timescale 1ns/1ps
module slt_led_trig_test;
   import slt_pkg::*;
   localparam int SLOT = 8;
   localparam int COMM = 20;
   logic sys_clk = 0;
   logic rstn = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_we = 0;
   logic reg_re = 0;
   logic [31:0] reg_rdata;
   slt_sys_type sys_flags = '0;
   slt_evt_type veh_evt = '0;
   logic comm_check = 0;
   logic red_led, green_led, trig, aux;
   logic pol = 0;
   logic aux_on = 0;
   logic [31:0] rd_v;
   int pulses, last_w, apulses, alast_w;
   int tests_run = 0;
   int bad_count = 0;
   int pres = 0;
   int on_r, on_g, rise_r, alt, w, p0, a0, xp, k, cnt, bad_t;

   slt_led_trig #(.SLOT_CYCLES(SLOT), .COMM_CYCLES(COMM)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .sys_flags(sys_flags), .veh_evt(veh_evt),
      .comm_check(comm_check), .red_led(red_led), .green_led(green_led),
      .vehicle_trigger_out(trig), .aux_trigger_out(aux));
   // One camera on each trigger pin
   slt_cam_model cam (.sys_clk(sys_clk), .trig_pin(trig), .act_high(pol),
      .pulses(pulses), .last_w(last_w));
   slt_cam_model cam_aux (.sys_clk(sys_clk), .trig_pin(aux),
      .act_high(pol), .pulses(apulses), .last_w(alast_w));

   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;

   task automatic complete_run();
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg,
                  seen, exp);
      end
   endtask

   // Sampling sits 1 ns past the edge so the edge's updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge sys_clk);
      reg_we <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge sys_clk);
      reg_re <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask

   // Event pulse plus the bench's own count of vehicles in beam two
   task automatic ev(input slt_evt_type e);
      @(posedge sys_clk);
      veh_evt <= e;
      @(posedge sys_clk);
      veh_evt <= '0;
      if (e.det2) pres++;
      if (e.eov2 && pres > 0) pres--;
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      rstn <= 1'b0;
      sys_flags <= '0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      cyc(6);
      pres = 0;
      pol = 0;
      aux_on = 0;
   endtask

   // Indicator statistics over n cycles; any n-cycle span of a period works
   task automatic watch(input int n);
      logic pr;
      on_r = 0;
      on_g = 0;
      rise_r = 0;
      alt = 0;
      cyc(2);
      pr = red_led;
      repeat (n) begin
         cyc(1);
         on_r += (red_led === 1'b1);
         on_g += (green_led === 1'b1);
         alt += (red_led === green_led);
         rise_r += (red_led === 1'b1 && pr === 1'b0);
         pr = red_led;
      end
   endtask

   // Poll the state field with a bounded number of reads
   task automatic wait_state(input logic [2:0] s, input int n);
      k = 0;
      rd(ADDR_STATUS);
      while (rd_v[2:0] !== s && k < n) begin
         k++;
         rd(ADDR_STATUS);
      end
   endtask

   // Main sequence
   initial begin
      void'($urandom(60346));
      do_reset();
      check({red_led, green_led}, 2'b00, "dark after reset");
      check(trig, 1'b1, "trigger idle high");
      check(aux, 1'b1, "aux idle");
      rd(ADDR_CTRL);
      check(rd_v, 32'h4, "ctrl reset");
      rd(ADDR_WIDTH);
      check(rd_v, 32'(WIDTH_RST), "width reset");
      rd(4'hc);
      check(rd_v, 32'h0, "unmapped read");
      $display("test reset done");

      @(posedge sys_clk);
      sys_flags.image_ok <= 1'b1;
      watch(64);
      check(on_g, 32, "boot green blink");
      check(on_r, 0, "boot red dark");
      wait_state(3'h3, 300);
      check(rd_v[2:0], 3'h3, "init after boot delay");
      watch(64);
      check(alt, 0, "init alternates");
      check(on_r, 32, "init flash rate");
      wait_state(3'h4, 1930);
      check(rd_v[2:0], 3'h4, "init bounded");
      check({red_led, green_led}, 2'b01, "calibration lamps");
      @(posedge sys_clk);
      sys_flags.cal_done <= 1'b1;
      cyc(4);
      check({red_led, green_led}, 2'b11, "normal idle");
      $display("test start-up done");

      // Every mode and beam, random width, polarity and aux fitting
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 2; b++) begin
            w = 1 + $urandom % 40;
            pol = $urandom % 2;
            aux_on = $urandom % 2;
            wr(ADDR_WIDTH, 32'(w));
            wr(ADDR_CTRL, {27'h0, aux_on, pol, b[0], m[1:0]});
            cyc(4);
            check(trig, !pol, "idle level");
            for (int e = 0; e < 4; e++) begin
               p0 = pulses;
               a0 = apulses;
               ev(slt_evt_type'(4'h8 >> e));
               cyc(w + 8);
               xp = (m < 2) ? (e == (m == 0 ? 2 : 0) + b) : (m == 2 && e == 3);
               check(pulses - p0, xp, "trigger count");
               if (m < 2 && xp) check(last_w, w, "pulse width");
               check(apulses - a0, aux_on ? xp : 0, "aux count");
               check(aux, aux_on ? trig : !pol, "aux level");
               check(green_led, pres == 0, "green by beam 2");
               check(red_led, 1'b1, "red steady");
               if (m == 2) check(trig, pres > 0 ? pol : !pol, "presence");
            end
         end
      end
      $display("test trigger modes done");

      wr(ADDR_CTRL, 32'h4);
      pol = 0;
      @(posedge sys_clk);
      comm_check <= 1'b1;
      @(posedge sys_clk);
      comm_check <= 1'b0;
      #1;
      k = 0;
      while (green_led !== 1'b0 && k < 6) begin
         cyc(1);
         k++;
      end
      cnt = 0;
      bad_t = 0;
      while (green_led === 1'b0 && cnt < 100) begin
         cnt++;
         bad_t += (trig !== 1'b0);
         cyc(1);
      end
      check(cnt, COMM, "comm window");
      check(bad_t, 0, "trigger with green");
      check(trig, 1'b1, "trigger restored");
      $display("test comm check done");

      @(posedge sys_clk);
      sys_flags.crit_fail <= 1'b1;
      watch(64);
      check(on_r, 32, "critical on time");
      check(rise_r, 4, "critical flashes");
      @(posedge sys_clk);
      sys_flags.crit_fail <= 1'b0;
      sys_flags.noncrit_fail <= 1'b1;
      watch(64);
      check(on_r, SLOT, "noncritical on time");
      check(rise_r, 1, "noncritical flash");
      check(on_g, 64, "green unchanged");
      $display("test faults done");

      do_reset();
      @(posedge sys_clk);
      sys_flags.image_bad <= 1'b1;
      watch(64);
      check(rise_r, 4, "bad image red flashes");
      check(on_g, 0, "bad image green dark");
      wr(ADDR_STATUS, 32'h3f);
      cyc(600);
      rd(ADDR_STATUS);
      check(rd_v[2:0], 3'h2, "stays in boot");
      do_reset();
      @(posedge sys_clk);
      sys_flags.image_ok <= 1'b1;
      sys_flags.selftest_fail <= 1'b1;
      watch(64);
      check(on_g, 0, "self-test green off");
      check(on_r, 32, "self-test red flash");
      cyc(600);
      rd(ADDR_STATUS);
      check(rd_v[2:0], 3'h2, "no initialisation");
      $display("test boot failures done");
      complete_run();
   end

   // Watchdog well beyond the expected run of about 7000 cycles
   initial begin
      #(5 * 40000);
      bad_count++;
      $display("watchdog expired");
      complete_run();
   end
endmodule
